// >>> hdl/bcc_pkg.sv
// Package with status codes, states and timing constants
package bcc_pkg;

  localparam int unsigned CLK_HZ       = 10_000_000;
  localparam int unsigned GRANT_MIN_NS = 110;
  localparam int unsigned GRANT_MAX_NS = 250;
  // Least time rounds up, longest rounds down, never below one cycle
  localparam int unsigned GRANT_MIN_RAW = (GRANT_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned GRANT_MAX_RAW = (GRANT_MAX_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int unsigned GRANT_CYC     = (GRANT_MIN_RAW < 1) ? 1 : GRANT_MIN_RAW;
  localparam int unsigned SYNC_STAGES   = 2;
  // Pin synchroniser already spends part of the least delay; count only the rest
  localparam int unsigned GRANT_EXTRA   = (GRANT_CYC > SYNC_STAGES) ? GRANT_CYC - SYNC_STAGES : 0;
  localparam logic [1:0]  GRANT_CNT_MAX = 2'(GRANT_EXTRA);

  typedef enum logic [2:0] {
    ST_IRQ_ACK  = 3'h0,
    ST_IO_READ  = 3'h1,
    ST_IO_WRITE = 3'h2,
    ST_HALT     = 3'h3,
    ST_CODE     = 3'h4,
    ST_MEM_READ = 3'h5,
    ST_MEM_WRT  = 3'h6,
    ST_PASSIVE  = 3'h7
  } bcc_status_t;

  // Machine cycle phases, Gray coded along the path
  typedef enum logic [1:0] {
    PH_IDLE  = 2'b00,
    PH_ADDR  = 2'b01,
    PH_CMD   = 2'b11,
    PH_LATE  = 2'b10
  } bcc_phase_t;

  localparam logic [2:0] STATUS_RESET = 3'h7;

endpackage

// >>> hdl/bcc_grant_if.sv
// Interface carrying the bus grant qualification between modules
`timescale 1ns/1ps
interface bcc_grant_if;
  logic grant_req;
  logic grant_ok;
  modport timer (input grant_req, output grant_ok);
  modport user  (output grant_req, input grant_ok);
endinterface

// >>> hdl/bcc_grant_timer.sv
// Delay from bus grant low to command enable
`timescale 1ns/1ps
module bcc_grant_timer (
  // Clock and reset
  input  wire logic     clk,
  input  wire logic     rst_n,
  // Grant handshake
  bcc_grant_if.timer    gi
);

  logic [1:0] count;

  wire count_done = (count == bcc_pkg::GRANT_CNT_MAX);

  // Enable after the least delay, drop at once on release
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= 2'h0;
    end else if (!gi.grant_req) begin
      count <= 2'h0;
    end else if (!count_done) begin
      count <= count + 2'h1;
    end
  end

  // No extra register: a late enable would break the longest delay
  assign gi.grant_ok = count_done & gi.grant_req; // [R8] [R9]

endmodule

// >>> hdl/bcc_top.sv
// Bus command controller: status decode into command and control strobes
`timescale 1ns/1ps
// Functional notes
// (R1) Decode status, clocked command and control timing
// (R2) Passive code keeps all commands high
// (R3) Status code selects command per decode table
// (R4) Address strobe high once per machine cycle
// (R5) Address strobe latches status for halt
// (R6) Data enable high enables data transceivers
// (R7) Direction high on writes, low on reads
// (R8) Commands enabled 110 to 250 ns after grant
// (R9) Grant release tri-states commands at once
// (R10) IO mode: grant ignored for IO commands
// (R11) System mode: commands wait for grant
// (R12) Qualifier low forces commands and enables inactive
// (R13) Strap high IO mode, low system mode
// (R14) IO mode: IO commands start immediately
// (R15) Early IO write timed like read
// (R16) Early memory write timed like read
// (R17) IO write strobe active low
// (R18) IO read strobe active low
// (R19) Memory write strobe active low
// (R20) Memory read strobe active low
// (R21) Interrupt acknowledge strobe active low
// (R22) System mode: cascade enable high in interrupts
// (R23) IO mode: peripheral enable active low
// (R24) Passive code returns sequencing to idle
module bcc_top (
  // Clock and reset
  input  wire logic       CLK_I,
  input  wire logic       RST_N_I,
  // Processor status
  input  wire logic [2:0] CPU_STATUS_CODE_I,
  // Arbitration and qualifiers
  input  wire logic       BUS_GRANT_N_I,
  input  wire logic       COMMAND_QUALIFIER_I,
  input  wire logic       IO_BUS_MODE_STRAP_I,
  // Command strobes and the output enables of their three-state drivers
  output logic            MEM_READ_N_O,
  output logic            MEM_WRITE_N_O,
  output logic            EARLY_MEM_WRITE_N_O,
  output logic            IO_READ_N_O,
  output logic            IO_WRITE_N_O,
  output logic            EARLY_IO_WRITE_N_O,
  output logic            IRQ_ACK_N_O,
  output logic            MEM_CMD_OE_O,
  output logic            IO_CMD_OE_O,
  // Control outputs
  output logic            ADDR_STROBE_O,
  output logic            XCVR_ENABLE_O,
  output logic            XFER_DIRECTION_O,
  output logic            CASCADE_PERIPH_O
);

  // Two-flop synchronisers for all pin inputs
  logic [2:0] status_meta;
  logic [2:0] status_sync;
  logic [2:0] misc_meta;
  logic [2:0] misc_sync;

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      status_meta <= bcc_pkg::STATUS_RESET;
      status_sync <= bcc_pkg::STATUS_RESET;
      misc_meta   <= 3'h3;
      misc_sync   <= 3'h3;
    end else begin
      status_meta <= CPU_STATUS_CODE_I;
      status_sync <= status_meta;
      misc_meta   <= {IO_BUS_MODE_STRAP_I, COMMAND_QUALIFIER_I, BUS_GRANT_N_I};
      misc_sync   <= misc_meta;
    end
  end

  wire grant_n   = misc_sync[0];
  wire qualifier = misc_sync[1];
  wire io_mode   = misc_sync[2]; // [R13]

  // Status seen last cycle, to find a new machine cycle
  logic [2:0] status_prev;
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      status_prev <= bcc_pkg::STATUS_RESET;
    end else begin
      status_prev <= status_sync;
    end
  end

  wire is_passive = (status_sync == bcc_pkg::ST_PASSIVE);
  wire cycle_start = (status_prev == bcc_pkg::ST_PASSIVE) && !is_passive;

  // Machine cycle sequencer
  bcc_pkg::bcc_phase_t phase;
  bcc_pkg::bcc_phase_t next_phase;
  logic [2:0]          cmd_code;
  logic [2:0]          next_cmd_code;

  always_comb begin
    next_phase    = phase;
    next_cmd_code = cmd_code;
    case (phase)
      bcc_pkg::PH_IDLE: begin
        if (cycle_start) begin
          next_phase    = bcc_pkg::PH_ADDR;
          next_cmd_code = status_sync; // [R5]
        end
      end
      bcc_pkg::PH_ADDR: begin
        next_phase = bcc_pkg::PH_CMD;
      end
      bcc_pkg::PH_CMD: begin
        next_phase = bcc_pkg::PH_LATE;
      end
      bcc_pkg::PH_LATE: begin
        next_phase = bcc_pkg::PH_LATE;
      end
      default: begin
        next_phase = bcc_pkg::PH_IDLE;
      end
    endcase
    // Passive code ends the cycle; no reset pin on the real part
    if (is_passive) begin
      next_phase    = bcc_pkg::PH_IDLE; // [R24]
      next_cmd_code = bcc_pkg::STATUS_RESET;
    end
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      phase    <= bcc_pkg::PH_IDLE;
      cmd_code <= bcc_pkg::STATUS_RESET;
    end else begin
      phase    <= next_phase; // [R1]
      cmd_code <= next_cmd_code;
    end
  end

  // Phase windows: early strobes from command phase, late ones one cycle on
  wire in_cmd   = (phase == bcc_pkg::PH_CMD) || (phase == bcc_pkg::PH_LATE);
  wire in_late  = (phase == bcc_pkg::PH_LATE);
  wire in_cycle = (phase != bcc_pkg::PH_IDLE);

  // Command decode from latched code
  wire dec_irq_ack_n  = (cmd_code == bcc_pkg::ST_IRQ_ACK); // [R3]
  wire dec_ior   = (cmd_code == bcc_pkg::ST_IO_READ);
  wire dec_iow   = (cmd_code == bcc_pkg::ST_IO_WRITE);
  wire dec_mrd   = (cmd_code == bcc_pkg::ST_CODE) || (cmd_code == bcc_pkg::ST_MEM_READ);
  wire dec_mwr   = (cmd_code == bcc_pkg::ST_MEM_WRT);
  wire dec_halt  = (cmd_code == bcc_pkg::ST_HALT);
  wire dec_io    = dec_irq_ack_n | dec_ior | dec_iow;
  wire dec_write = dec_iow | dec_mwr;

  // Grant qualification through the delay timer
  bcc_grant_if gnt ();
  assign gnt.grant_req = !grant_n;

  bcc_grant_timer u_grant (
    .clk   (CLK_I),
    .rst_n (RST_N_I),
    .gi    (gnt)
  );

  // IO commands ignore grant in IO mode; all else waits for grant
  wire io_enabled  = io_mode | gnt.grant_ok; // [R10] [R11] [R14]
  wire mem_enabled = gnt.grant_ok;           // [R8] [R11]

  // Next values of registered outputs
  wire cmd_go = qualifier && !is_passive && !dec_halt; // [R2] [R12]

  wire next_mem_read   = !(cmd_go && in_cmd && dec_mrd && mem_enabled);   // [R20]
  wire next_mem_write  = !(cmd_go && in_late && dec_mwr && mem_enabled);  // [R19]
  wire next_emem_write = !(cmd_go && in_cmd && dec_mwr && mem_enabled);   // [R16]
  wire next_io_read    = !(cmd_go && in_cmd && dec_ior && io_enabled);    // [R18]
  wire next_io_write   = !(cmd_go && in_late && dec_iow && io_enabled);   // [R17]
  wire next_eio_write  = !(cmd_go && in_cmd && dec_iow && io_enabled);    // [R15]
  wire next_irq_ack    = !(cmd_go && in_cmd && dec_irq_ack_n && io_enabled);   // [R21]

  // Address strobe: one cycle high at start of each machine cycle
  wire next_addr_strobe = cycle_start; // [R4]

  // Data enables: system enable unless IO mode owns the IO transfer
  wire xfer_active  = cmd_go && in_cmd && !dec_halt;
  wire io_on_periph = io_mode && dec_io;
  wire next_xcvr_en = xfer_active && !io_on_periph; // [R6] [R12] [R21]
  wire next_dir     = in_cycle && dec_write;                      // [R7]

  // Dual function pin; first acknowledge not masked here, left to board logic
  wire next_cascade = io_mode ? !(xfer_active && io_on_periph)    // [R23]
                              : (cmd_go && in_cycle && dec_irq_ack_n); // [R22]

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      MEM_READ_N_O        <= 1'b1;
      MEM_WRITE_N_O       <= 1'b1;
      EARLY_MEM_WRITE_N_O <= 1'b1;
      IO_READ_N_O         <= 1'b1;
      IO_WRITE_N_O        <= 1'b1;
      EARLY_IO_WRITE_N_O  <= 1'b1;
      IRQ_ACK_N_O         <= 1'b1;
      ADDR_STROBE_O       <= 1'b0;
      XCVR_ENABLE_O       <= 1'b0;
      XFER_DIRECTION_O    <= 1'b0;
      CASCADE_PERIPH_O    <= 1'b0;
    end else begin
      MEM_READ_N_O        <= next_mem_read;
      MEM_WRITE_N_O       <= next_mem_write;
      EARLY_MEM_WRITE_N_O <= next_emem_write;
      IO_READ_N_O         <= next_io_read;
      IO_WRITE_N_O        <= next_io_write;
      EARLY_IO_WRITE_N_O  <= next_eio_write;
      IRQ_ACK_N_O         <= next_irq_ack;
      ADDR_STROBE_O       <= next_addr_strobe;
      XCVR_ENABLE_O       <= next_xcvr_en;
      XFER_DIRECTION_O    <= next_dir;
      CASCADE_PERIPH_O    <= next_cascade;
    end
  end

  // Output enables for the three-state command drivers
  assign MEM_CMD_OE_O = mem_enabled; // [R9]
  assign IO_CMD_OE_O  = io_enabled;  // [R9] [R10]

endmodule

// >>> dv/bcc_props.sv
// Checker of strobe timing at the controller ports
`timescale 1ns/1ps
module bcc_props (
  // Clock and reset
  input logic       CLK_I,
  input logic       RST_N_I,
  // Inputs
  input logic [2:0] CPU_STATUS_CODE_I,
  input logic       BUS_GRANT_N_I,
  input logic       COMMAND_QUALIFIER_I,
  // Outputs
  input logic       MEM_READ_N_O,
  input logic       MEM_WRITE_N_O,
  input logic       EARLY_MEM_WRITE_N_O,
  input logic       IO_READ_N_O,
  input logic       IO_WRITE_N_O,
  input logic       IRQ_ACK_N_O,
  input logic       MEM_CMD_OE_O,
  input logic       ADDR_STROBE_O,
  input logic       XCVR_ENABLE_O,
  input logic       XFER_DIRECTION_O
);
  logic [2:0] idle;
  wire        quiet = &{MEM_READ_N_O, MEM_WRITE_N_O, EARLY_MEM_WRITE_N_O, IO_READ_N_O,
                        IO_WRITE_N_O, IRQ_ACK_N_O};
  // Passive samples; sync latency needs a few
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      idle <= 3'h0;
    end else if (CPU_STATUS_CODE_I != 3'h7) begin
      idle <= 3'h0;
    end else if (idle != 3'h7) begin
      idle <= idle + 3'h1;
    end
  end
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  property p_passive; idle >= 3'h4 |-> quiet; endproperty
  a_passive: assert property (p_passive) else $error("strobe while passive");
  property p_ale; ADDR_STROBE_O |=> !ADDR_STROBE_O; endproperty
  a_ale: assert property (p_ale) else $error("address strobe too long");
  property p_qual; !COMMAND_QUALIFIER_I [*4] |-> quiet && !XCVR_ENABLE_O; endproperty
  a_qual: assert property (p_qual) else $error("qualifier ignored");
  property p_gmin; $rose(MEM_CMD_OE_O) |-> !$past(BUS_GRANT_N_I) && !$past(BUS_GRANT_N_I, 2);
  endproperty
  a_gmin: assert property (p_gmin) else $error("enable too early");
  property p_gmax; $fell(BUS_GRANT_N_I) ##1 !BUS_GRANT_N_I [*2] |-> MEM_CMD_OE_O; endproperty
  a_gmax: assert property (p_gmax) else $error("enable too late");
  property p_rel; BUS_GRANT_N_I [*3] |-> !MEM_CMD_OE_O; endproperty
  a_rel: assert property (p_rel) else $error("drivers not released");
  property p_dir; !MEM_WRITE_N_O || !IO_WRITE_N_O |-> XFER_DIRECTION_O; endproperty
  a_dir: assert property (p_dir) else $error("direction low on write");
  property p_early; $fell(MEM_WRITE_N_O) |-> !$past(EARLY_MEM_WRITE_N_O); endproperty
  a_early: assert property (p_early) else $error("early write not first");
  c_read: cover property (!MEM_READ_N_O);
  c_write: cover property ($fell(MEM_WRITE_N_O));
  c_grant: cover property ($rose(MEM_CMD_OE_O));
endmodule
bind bcc_top bcc_props u_bcc_props (.*);

// >>> dv/bcc_cpu_model.sv
// Processor status and bus arbiter model
`timescale 1ns/1ps
module bcc_cpu_model (
  // Clock
  input  logic       clk_i,
  // Status and grant
  output logic [2:0] status_o,
  output logic       grant_n_o
);
  initial begin
    status_o = 3'h7;
    grant_n_o = 1'h1;
  end
  // Callers frame every code with passive
  task automatic set(input logic [2:0] code);
    @(posedge clk_i);
    #1 status_o = code;
  endtask
  task automatic grant(input logic g);
    @(posedge clk_i);
    #1 grant_n_o = !g;
  endtask
endmodule

// >>> dv/tb.sv
// Self-checking bench for the bus command controller
`timescale 1ns/1ps
module tb;
  logic       clk;
  logic       rst_n;
  logic       qual;
  logic       strap;
  logic [2:0] st;
  logic       gnt_n;
  logic       mrd, mwr, amw, ird, iwr, aiw, ack, moe, ioe, ale, xcvr_enable, dir, cas;
  wire  [6:0] strb = {mrd, mwr, amw, ird, iwr, aiw, ack};
  int         bad_count = 0;
  int         checks = 0;
  initial begin
    clk = 1'h0;
    forever #50 clk = !clk;
  end
  bcc_cpu_model u_bcc_cpu_model (.clk_i(clk), .status_o(st), .grant_n_o(gnt_n));
  bcc_top u_bcc_top (.CLK_I(clk), .RST_N_I(rst_n), .CPU_STATUS_CODE_I(st),
    .BUS_GRANT_N_I(gnt_n), .COMMAND_QUALIFIER_I(qual), .IO_BUS_MODE_STRAP_I(strap),
    .MEM_READ_N_O(mrd), .MEM_WRITE_N_O(mwr), .EARLY_MEM_WRITE_N_O(amw), .IO_READ_N_O(ird),
    .IO_WRITE_N_O(iwr), .EARLY_IO_WRITE_N_O(aiw), .IRQ_ACK_N_O(ack), .MEM_CMD_OE_O(moe),
    .IO_CMD_OE_O(ioe), .ADDR_STROBE_O(ale), .XCVR_ENABLE_O(xcvr_enable),
    .XFER_DIRECTION_O(dir), .CASCADE_PERIPH_O(cas));
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict;
    $display("Checks %0d, mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // One machine cycle, judged after the late write phase
  task automatic run(input logic [2:0] c, input logic io, input logic q);
    logic [6:0] e;
    e = ~{q && c[2] && !c[1], {2{q && c == 3'h6}}, q && c == 3'h1, {2{q && c == 3'h2}},
      q && c == 3'h0};
    u_bcc_cpu_model.set(c);
    tick(3);
    chk("ale", 8'(ale), 8'(c != 3'h7));
    tick(2);
    chk("write phase", 8'({amw, mwr}), 8'({!(q && c == 3'h6), 1'h1}));
    tick(1);
    chk("strobes", 8'(strb), 8'(e));
    chk("dual", 8'(cas), 8'(io ? !(q && c < 3'h3) : c == 3'h0));
    if (c != 3'h3 && c != 3'h7) begin
      chk("dir", 8'(dir), 8'(c[1] && !c[0]));
      chk("den", 8'(xcvr_enable), 8'(q && !(io && c < 3'h3)));
    end
    u_bcc_cpu_model.set(3'h7);
    tick(4);
    chk("idle", 8'(strb), 8'h7f);
  endtask
  task automatic t_grant;
    int n;
    int ns;
    n = 0;
    u_bcc_cpu_model.set(3'h5);
    tick(6);
    chk("no grant", 8'({moe, ioe, mrd}), 8'h01);
    u_bcc_cpu_model.set(3'h7);
    u_bcc_cpu_model.grant(1'h1);
    while (moe !== 1'h1 && n < 20) begin
      tick(1);
      n++;
    end
    // Pin moved 1 ns after an edge, so n edges mean n*100-1 ns
    ns = n * 100 - 1;
    chk("grant early", 8'(ns >= bcc_pkg::GRANT_MIN_NS), 8'h01);
    chk("grant late", 8'(ns <= bcc_pkg::GRANT_MAX_NS), 8'h01);
    u_bcc_cpu_model.grant(1'h0);
    tick(2);
    chk("release", 8'(moe), 8'h00);
    u_bcc_cpu_model.grant(1'h1);
    tick(6);
    $display("grant test end");
  endtask
  task automatic t_decode;
    for (int c = 0; c < 8; c++) begin
      run(3'(c), 1'h0, 1'h1);
    end
    qual = 1'h0;
    tick(4);
    run(3'h5, 1'h0, 1'h0);
    run(3'h6, 1'h0, 1'h0);
    qual = 1'h1;
    $display("decode and qualifier test end");
  endtask
  task automatic t_iomode;
    strap = 1'h1;
    u_bcc_cpu_model.grant(1'h0);
    tick(4);
    chk("io mode oe", 8'({ioe, moe}), 8'h02);
    for (int c = 0; c < 3; c++) begin
      run(3'(c), 1'h1, 1'h1);
    end
    $display("io mode test end");
  endtask
  initial begin
    rst_n = 1'h0;
    qual = 1'h1;
    strap = 1'h0;
    tick(8);
    rst_n = 1'h1;
    tick(2);
    chk("reset idle", 8'(strb), 8'h7f);
    t_grant;
    t_decode;
    t_iomode;
    give_verdict;
  end
endmodule
